// ==== dtfc_pkg.sv ====
// Package for the device transport frame controller: states, frame types, widths and counts.
// Assumes one clock domain, with the link and application logic on the same clock.
// Operation
// - Idle waits for a transmit request or an incoming-frame indication.
// - Register frame request from idle enters the register build state.
// - Set Device Bits request from idle enters the SDB build state.
// - PIO Setup request from idle enters the PIO Setup transmit entry.
// - DMA Activate request from idle enters the DMA Activate transmit entry.
// - DMA Setup request from idle enters the DMA setup transmit entry.
// - Data request from idle enters the data transmit entry.
// - BIST request from idle enters the BIST transmit state.
// - Incoming frame at idle enters type check, reading the type byte.
// - Register host-to-device type goes to command receive.
// - Data host-to-device type goes to outbound-data receive.
// - DMA Setup type goes to DMA setup receive.
// - BIST Activate type goes to BIST receive.
// - Unknown type or illegal-transition notice in type check returns to idle.
// - Register build assembles the frame, requests transmit, hands words over.
// - SDB build assembles the frame, requests transmit, hands words over.
// - After the last word, signal frame end and enter transmit status.
// - Transmit status waits for link ending status and handles errors.
// - Good ending status returns to idle.
// - Bad ending status reports to the link and rebuilds the frame.
// - Illegal-transition notice while building a register frame returns to idle.
// - PIO Setup is followed by exactly one data frame, direction per bit.
package dtfc_pkg;
  localparam int DTFC_WORD_W = 32;
  localparam int DTFC_CNT_W = 3;
  localparam logic [2:0] DTFC_REG_WORDS = 3'h5;
  localparam logic [2:0] DTFC_SDB_WORDS = 3'h2;
  localparam logic [7:0] DTFC_TYPE_REG_D2H = 8'h34;
  localparam logic [7:0] DTFC_TYPE_SDB = 8'ha1;
  localparam logic [7:0] DTFC_TYPE_REG_H2D = 8'h27;
  localparam logic [7:0] DTFC_TYPE_DATA = 8'h46;
  localparam logic [7:0] DTFC_TYPE_DMA_SETUP = 8'h41;
  localparam logic [7:0] DTFC_TYPE_BIST = 8'h58;
  localparam logic [2:0] DTFC_CNT_RESET = 3'h0;

  typedef enum logic [2:0] {
    DTFC_REQ_NONE, DTFC_REQ_REG, DTFC_REQ_SDB, DTFC_REQ_PIO, DTFC_REQ_DMA_ACT,
    DTFC_REQ_DMA_SETUP, DTFC_REQ_DATA, DTFC_REQ_BIST
  } dtfc_req_t;

  typedef enum logic [3:0] {
    idle_state, type_check_state, reg_build_state, reg_status_state, sdb_build_state,
    sdb_status_state, pio_setup_tx_entry, dma_activate_tx_entry, dma_setup_tx_entry,
    data_tx_entry, bist_tx_state, command_rx_state, data_rx_entry, dma_setup_rx_entry,
    bist_rx_state
  } dtfc_state_t;
endpackage

// ==== dtfc_tx_if.sv ====
// Interface carrying frame words from the framer to the controller's link port.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface dtfc_tx_if;
  import dtfc_pkg::*;
  logic start;
  logic is_sdb;
  logic [DTFC_WORD_W-1:0] word;
  logic [DTFC_CNT_W-1:0] index;
  logic last;
  modport ctrl (output start, output is_sdb, output index, input word, input last);
  modport framer (input start, input is_sdb, input index, output word, output last);
endinterface

// ==== dtfc_framer.sv ====
// Frame word builder for register and Set Device Bits frames.
// Assumes the controller walks the word index from zero while the link accepts words.
`timescale 1ns/1ps
module dtfc_framer (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [7:0] status_in,
  input wire logic [7:0] error_in,
  dtfc_tx_if.framer tx
);
  import dtfc_pkg::*;
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] error;
  } dtfc_frm_t;
  dtfc_frm_t st;
  dtfc_frm_t next_st;

  // The status bytes are captured at each frame start, a retry included, and held after.
  always_comb begin
    next_st = st;
    if (tx.start) begin
      next_st.status = status_in;
      next_st.error = error_in;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Word zero carries the type, the rest pad with zero in this compact framer.
  // It reads the bytes being captured, since the controller loads it in the start cycle.
  always_comb begin
    tx.word = '0;
    if (tx.index == DTFC_CNT_RESET) begin
      tx.word = {next_st.error, next_st.status, 8'h00,
        tx.is_sdb ? DTFC_TYPE_SDB : DTFC_TYPE_REG_D2H};
    end
    tx.last = tx.index == (tx.is_sdb ? DTFC_SDB_WORDS : DTFC_REG_WORDS) - 3'h1;
  end
endmodule

// ==== dtfc_status.sv ====
// Ending status evaluator: turns the link's good or bad answer into retry or done pulses.
// Assumes the link raises exactly one ending strobe per transmitted frame.
`timescale 1ns/1ps
module dtfc_status (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic waiting_in,
  input wire logic end_valid_in,
  input wire logic end_error_in,
  output logic done_out,
  output logic retry_out
);
  typedef struct packed {
    logic done;
    logic retry;
  } dtfc_sts_t;
  dtfc_sts_t st;
  dtfc_sts_t next_st;

  // Registering the verdict adds one cycle; status is reported in the first rebuild cycle.
  always_comb begin
    next_st.done = waiting_in && end_valid_in && !end_error_in;
    next_st.retry = waiting_in && end_valid_in && end_error_in;
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign done_out = st.done;
  assign retry_out = st.retry;
endmodule

// ==== dtfc_top.sv ====
// Device transport frame controller: idle dispatch, type check, register and SDB sequences.
// Assumes the link and application logic share clk_in; no synchronisers are needed.
`timescale 1ns/1ps
module dtfc_top (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire dtfc_pkg::dtfc_req_t app_req_in,
  input wire logic [7:0] app_status_in,
  input wire logic [7:0] app_error_in,
  input wire logic pio_dir_in,
  output logic app_req_ready_out,
  input wire logic link_rx_start_in,
  input wire logic [7:0] link_rx_type_in,
  input wire logic link_illegal_in,
  input wire logic link_word_ready_in,
  input wire logic link_end_valid_in,
  input wire logic link_end_error_in,
  output logic link_tx_req_out,
  output logic link_word_valid_out,
  output logic [dtfc_pkg::DTFC_WORD_W-1:0] link_word_out,
  output logic link_tx_done_out,
  output logic link_err_report_out,
  output logic pio_data_pending_out,
  output logic pio_data_dir_out,
  output dtfc_pkg::dtfc_state_t state_out
);
  import dtfc_pkg::*;

  typedef struct packed {
    dtfc_state_t state;
    logic [DTFC_CNT_W-1:0] index;
    logic [DTFC_WORD_W-1:0] word;
    logic word_valid;
    logic tx_done;
    logic err_report;
    logic pio_pending;
    logic pio_dir;
  } dtfc_ctl_t;

  dtfc_ctl_t st;
  dtfc_ctl_t next_st;
  dtfc_tx_if tx_bus ();
  logic wait_status;
  logic end_done;
  logic end_retry;
  logic building;
  logic build_sdb;

  assign building = (st.state == reg_build_state) || (st.state == sdb_build_state);
  assign build_sdb = st.state == sdb_build_state;
  assign wait_status = (st.state == reg_status_state) || (st.state == sdb_status_state);

  // Frame start is the first build cycle, so the framer captures fresh content each try.
  assign tx_bus.start = building && (st.index == DTFC_CNT_RESET) && !st.word_valid;
  assign tx_bus.is_sdb = build_sdb;
  assign tx_bus.index = st.index;

  dtfc_framer u_framer (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .status_in(app_status_in),
    .error_in(app_error_in),
    .tx(tx_bus)
  );

  dtfc_status u_status (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .waiting_in(wait_status),
    .end_valid_in(link_end_valid_in),
    .end_error_in(link_end_error_in),
    .done_out(end_done),
    .retry_out(end_retry)
  );

  // Next-state logic for the whole controller.
  always_comb begin
    next_st = st;
    next_st.tx_done = 1'b0;
    next_st.err_report = 1'b0;
    case (st.state)
      idle_state: begin
        // The incoming frame wins over a request, which stays held upstream.
        if (link_rx_start_in) begin
          next_st.state = type_check_state;
        end else begin
          case (app_req_in)
            DTFC_REQ_REG: next_st.state = reg_build_state;
            DTFC_REQ_SDB: next_st.state = sdb_build_state;
            DTFC_REQ_PIO: begin
              next_st.state = pio_setup_tx_entry;
              next_st.pio_pending = 1'b1;
              next_st.pio_dir = pio_dir_in;
            end
            DTFC_REQ_DMA_ACT: next_st.state = dma_activate_tx_entry;
            DTFC_REQ_DMA_SETUP: next_st.state = dma_setup_tx_entry;
            DTFC_REQ_DATA: next_st.state = data_tx_entry;
            DTFC_REQ_BIST: next_st.state = bist_tx_state;
            default: next_st.state = idle_state;
          endcase
        end
        next_st.index = DTFC_CNT_RESET;
        next_st.word_valid = 1'b0;
      end
      type_check_state: begin
        if (link_illegal_in) begin
          next_st.state = idle_state;
        end else if (link_rx_type_in == DTFC_TYPE_REG_H2D) begin
          next_st.state = command_rx_state;
        end else if (link_rx_type_in == DTFC_TYPE_DATA) begin
          next_st.state = data_rx_entry;
        end else if (link_rx_type_in == DTFC_TYPE_DMA_SETUP) begin
          next_st.state = dma_setup_rx_entry;
        end else if (link_rx_type_in == DTFC_TYPE_BIST) begin
          next_st.state = bist_rx_state;
        end else begin
          next_st.state = idle_state;
        end
      end
      reg_build_state, sdb_build_state: begin
        if (link_illegal_in) begin
          // Abort drops the word in flight; the link has already discarded the frame.
          next_st.state = idle_state;
          next_st.word_valid = 1'b0;
          next_st.index = DTFC_CNT_RESET;
        end else if (!st.word_valid) begin
          next_st.word = tx_bus.word;
          next_st.word_valid = 1'b1;
        end else if (link_word_ready_in) begin
          if (tx_bus.last) begin
            next_st.word_valid = 1'b0;
            next_st.index = DTFC_CNT_RESET;
            next_st.tx_done = 1'b1;
            next_st.state = build_sdb ? sdb_status_state : reg_status_state;
          end else begin
            next_st.index = st.index + 3'h1;
            next_st.word_valid = 1'b0;
          end
        end
      end
      reg_status_state, sdb_status_state: begin
        // The verdict arrives one cycle after the link strobe from the status unit.
        if (st.state == sdb_status_state && link_illegal_in) begin
          next_st.state = idle_state;
        end else if (end_done) begin
          next_st.state = idle_state;
        end else if (end_retry) begin
          next_st.err_report = 1'b1;
          next_st.state = (st.state == sdb_status_state) ? sdb_build_state : reg_build_state;
        end
      end
      pio_setup_tx_entry: begin
        // The PIO sequence body lives elsewhere; only its data pairing is tracked here.
        next_st.state = idle_state;
      end
      data_tx_entry, data_rx_entry: begin
        // The one data frame after a PIO Setup clears the pending mark.
        next_st.pio_pending = 1'b0;
        next_st.state = idle_state;
      end
      default: begin
        // Other sequence bodies are outside this block and hand back at once.
        next_st.state = idle_state;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st <= '{state: idle_state, index: DTFC_CNT_RESET, default: '0};
    end else begin
      st <= next_st;
    end
  end

  // A request is only taken in idle with no incoming frame competing.
  assign app_req_ready_out = (st.state == idle_state) && !link_rx_start_in;
  assign link_tx_req_out = building;
  assign link_word_valid_out = st.word_valid;
  assign link_word_out = st.word;
  assign link_tx_done_out = st.tx_done;
  assign link_err_report_out = st.err_report;
  assign pio_data_pending_out = st.pio_pending;
  assign pio_data_dir_out = st.pio_dir;
  assign state_out = st.state;

  sequence s_good_end;
    wait_status && link_end_valid_in && !link_end_error_in && !link_illegal_in;
  endsequence
  sequence s_bad_end;
    wait_status && link_end_valid_in && link_end_error_in && !link_illegal_in;
  endsequence

  property p_rx_wins;
    @(posedge clk_in) disable iff (!rstn_in)
      (st.state == idle_state && link_rx_start_in) |=> st.state == type_check_state;
  endproperty
  a_rx_wins: assert property (p_rx_wins) else $error("Incoming frame did not win.");

  property p_reg_req;
    @(posedge clk_in) disable iff (!rstn_in)
      (st.state == idle_state && !link_rx_start_in && app_req_in == DTFC_REQ_REG)
      |=> st.state == reg_build_state;
  endproperty
  a_reg_req: assert property (p_reg_req) else $error("Register request not taken.");

  property p_sdb_req;
    @(posedge clk_in) disable iff (!rstn_in)
      (st.state == idle_state && !link_rx_start_in && app_req_in == DTFC_REQ_SDB)
      |=> st.state == sdb_build_state;
  endproperty
  a_sdb_req: assert property (p_sdb_req) else $error("SDB request not taken.");

  property p_idle_hold;
    @(posedge clk_in) disable iff (!rstn_in)
      (st.state == idle_state && !link_rx_start_in && app_req_in == DTFC_REQ_NONE)
      |=> st.state == idle_state;
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("Idle left without cause.");

  property p_bad_type;
    @(posedge clk_in) disable iff (!rstn_in)
      (st.state == type_check_state && link_illegal_in) |=> st.state == idle_state;
  endproperty
  a_bad_type: assert property (p_bad_type) else $error("Type check ignored notice.");

  property p_cmd_type;
    @(posedge clk_in) disable iff (!rstn_in)
      (st.state == type_check_state && !link_illegal_in
       && link_rx_type_in == DTFC_TYPE_REG_H2D) |=> st.state == command_rx_state;
  endproperty
  a_cmd_type: assert property (p_cmd_type) else $error("Command frame misrouted.");

  property p_good_end;
    @(posedge clk_in) disable iff (!rstn_in)
      s_good_end |=> ##1 st.state == idle_state;
  endproperty
  a_good_end: assert property (p_good_end) else $error("Good status did not idle.");

  property p_bad_end;
    @(posedge clk_in) disable iff (!rstn_in)
      s_bad_end |=> ##1 (link_err_report_out && building);
  endproperty
  a_bad_end: assert property (p_bad_end) else $error("Bad status did not retry.");

  property p_reg_abort;
    @(posedge clk_in) disable iff (!rstn_in)
      (st.state == reg_build_state && link_illegal_in) |=> st.state == idle_state;
  endproperty
  a_reg_abort: assert property (p_reg_abort) else $error("Register build not aborted.");

  property p_done_pulse;
    @(posedge clk_in) disable iff (!rstn_in)
      $rose(link_tx_done_out) |-> wait_status && $past(link_word_valid_out);
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("Frame end out of place.");

  // Remaining dispatch and routing, then the word handshake, the SDB abort and the PIO data clear.
  property p_pio_req;
    @(posedge clk_in) disable iff (!rstn_in)
      (st.state == idle_state && !link_rx_start_in && app_req_in == DTFC_REQ_PIO)
      |=> st.state == pio_setup_tx_entry && pio_data_pending_out;
  endproperty
  a_pio_req: assert property (p_pio_req) else $error("PIO request not taken.");

  property p_dma_act_req;
    @(posedge clk_in) disable iff (!rstn_in)
      (st.state == idle_state && !link_rx_start_in && app_req_in == DTFC_REQ_DMA_ACT)
      |=> st.state == dma_activate_tx_entry;
  endproperty
  a_dma_act_req: assert property (p_dma_act_req) else $error("Activate not taken.");

  property p_dma_setup_req;
    @(posedge clk_in) disable iff (!rstn_in)
      (st.state == idle_state && !link_rx_start_in && app_req_in == DTFC_REQ_DMA_SETUP)
      |=> st.state == dma_setup_tx_entry;
  endproperty
  a_dma_setup_req: assert property (p_dma_setup_req) else $error("Setup not taken.");

  property p_data_req;
    @(posedge clk_in) disable iff (!rstn_in)
      (st.state == idle_state && !link_rx_start_in && app_req_in == DTFC_REQ_DATA)
      |=> st.state == data_tx_entry;
  endproperty
  a_data_req: assert property (p_data_req) else $error("Data request not taken.");

  property p_bist_req;
    @(posedge clk_in) disable iff (!rstn_in)
      (st.state == idle_state && !link_rx_start_in && app_req_in == DTFC_REQ_BIST)
      |=> st.state == bist_tx_state;
  endproperty
  a_bist_req: assert property (p_bist_req) else $error("BIST request not taken.");

  property p_data_type;
    @(posedge clk_in) disable iff (!rstn_in)
      (st.state == type_check_state && !link_illegal_in && link_rx_type_in == DTFC_TYPE_DATA)
      |=> st.state == data_rx_entry;
  endproperty
  a_data_type: assert property (p_data_type) else $error("Data frame misrouted.");

  property p_setup_type;
    @(posedge clk_in) disable iff (!rstn_in)
      (st.state == type_check_state && !link_illegal_in && link_rx_type_in == DTFC_TYPE_DMA_SETUP)
      |=> st.state == dma_setup_rx_entry;
  endproperty
  a_setup_type: assert property (p_setup_type) else $error("Setup frame misrouted.");

  property p_bist_type;
    @(posedge clk_in) disable iff (!rstn_in)
      (st.state == type_check_state && !link_illegal_in && link_rx_type_in == DTFC_TYPE_BIST)
      |=> st.state == bist_rx_state;
  endproperty
  a_bist_type: assert property (p_bist_type) else $error("BIST frame misrouted.");

  property p_word_hold;
    @(posedge clk_in) disable iff (!rstn_in)
      (link_word_valid_out && !link_word_ready_in && !link_illegal_in)
      |=> link_word_valid_out && $stable(link_word_out);
  endproperty
  a_word_hold: assert property (p_word_hold) else $error("Word not held.");

  property p_last_word;
    @(posedge clk_in) disable iff (!rstn_in)
      (building && link_word_valid_out && link_word_ready_in && tx_bus.last && !link_illegal_in)
      |=> link_tx_done_out && wait_status;
  endproperty
  a_last_word: assert property (p_last_word) else $error("Last word not closed.");

  property p_sdb_abort;
    @(posedge clk_in) disable iff (!rstn_in)
      ((st.state == sdb_build_state || st.state == sdb_status_state) && link_illegal_in)
      |=> st.state == idle_state;
  endproperty
  a_sdb_abort: assert property (p_sdb_abort) else $error("SDB not aborted.");

  property p_pio_clear;
    @(posedge clk_in) disable iff (!rstn_in)
      (st.state == data_tx_entry || st.state == data_rx_entry)
      |=> !pio_data_pending_out && st.state == idle_state;
  endproperty
  a_pio_clear: assert property (p_pio_clear) else $error("PIO mark not cleared.");
endmodule

// ==== dtfc_link_model.sv ====
// Link layer model for the transport controller: takes frame words, returns ending status.
// Assumes the bench drives on the falling edge; this model changes its outputs there too.
`timescale 1ns/1ps
module dtfc_link_model (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [2:0] stall_in,
  input wire logic bad_in,
  input wire logic word_valid_in,
  input wire logic [31:0] word_in,
  input wire logic tx_done_in,
  output logic word_ready_out,
  output logic end_valid_out,
  output logic end_error_out
);
  logic [31:0] words [0:15];
  logic [3:0] n_words;
  logic [2:0] wait_cnt;
  logic [2:0] end_cnt;
  // Words are stored at the edge where valid and ready meet.
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      n_words <= 4'h0;
    end else if (word_valid_in && word_ready_out) begin
      words[n_words] <= word_in;
      n_words <= n_words + 4'h1;
    end
  end
  // Ready waits stall_in cycles per word; status comes stall_in plus one cycles after frame end is seen.
  always @(negedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      word_ready_out <= 1'b0;
      wait_cnt <= 3'h0;
      end_cnt <= 3'h0;
      end_valid_out <= 1'b0;
      end_error_out <= 1'b0;
    end else begin
      end_valid_out <= 1'b0;
      end_error_out <= ~end_error_out; // The flag means nothing outside the strobe.
      if (word_ready_out) begin
        word_ready_out <= 1'b0;
        wait_cnt <= stall_in;
      end else if (word_valid_in && wait_cnt == 3'h0) begin
        word_ready_out <= 1'b1;
      end else if (word_valid_in) begin
        wait_cnt <= wait_cnt - 3'h1;
      end
      if (tx_done_in) begin
        end_cnt <= stall_in + 3'h1;
      end else if (end_cnt == 3'h1) begin
        end_valid_out <= 1'b1;
        end_error_out <= bad_in;
        end_cnt <= 3'h0;
      end else if (end_cnt != 3'h0) begin
        end_cnt <= end_cnt - 3'h1;
      end
    end
  end
endmodule

// ==== tb_device_transport_fis_control.sv ====
// Self-checking bench for the transport controller with a link layer model below it.
// Assumes the bench acts as the application layer and drives on the falling edge.
`timescale 1ns/1ps
module tb_device_transport_fis_control;
  import dtfc_pkg::*;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  dtfc_req_t app_req = DTFC_REQ_NONE;
  logic [7:0] app_status = 8'h00;
  logic [7:0] app_error = 8'h00;
  logic pio_dir = 1'b0;
  logic rx_start = 1'b0;
  logic [7:0] rx_type = 8'h00;
  logic illegal = 1'b0;
  logic [2:0] stall = 3'h0;
  logic bad_r = 1'b0;
  logic ready, word_ready, end_valid, end_error, tx_req, word_valid, tx_done, err_rep;
  logic pio_pend, pio_dir_o;
  logic [31:0] word;
  dtfc_state_t state;
  dtfc_state_t st_done;
  int fails = 0;
  int checks_done = 0;
  int done_cnt = 0;
  dtfc_top uut (.clk_in(clk_in), .rstn_in(rstn_in), .app_req_in(app_req),
    .app_status_in(app_status), .app_error_in(app_error), .pio_dir_in(pio_dir),
    .app_req_ready_out(ready), .link_rx_start_in(rx_start), .link_rx_type_in(rx_type),
    .link_illegal_in(illegal), .link_word_ready_in(word_ready),
    .link_end_valid_in(end_valid), .link_end_error_in(end_error), .link_tx_req_out(tx_req),
    .link_word_valid_out(word_valid), .link_word_out(word), .link_tx_done_out(tx_done),
    .link_err_report_out(err_rep), .pio_data_pending_out(pio_pend),
    .pio_data_dir_out(pio_dir_o), .state_out(state));
  dtfc_link_model lk (.clk_in(clk_in), .rstn_in(rstn_in), .stall_in(stall), .bad_in(bad_r),
    .word_valid_in(word_valid), .word_in(word), .tx_done_in(tx_done),
    .word_ready_out(word_ready), .end_valid_out(end_valid), .end_error_out(end_error));
  // Clock at 50 ns period.
  initial begin
    forever #25 clk_in = ~clk_in;
  end
  // Frame-end pulses are counted and the state they show in is kept.
  always @(negedge clk_in) begin
    if (tx_done === 1'b1) begin
      done_cnt++;
      st_done = state;
    end
  end
  task automatic close_out();
    if (fails == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_st(input dtfc_state_t got, input dtfc_state_t exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: state %h expected %h", $time, got, exp);
    end
  endtask
  // Bounded wait for a state; running out counts as a mismatch and ends the run.
  task automatic wait_st(input dtfc_state_t exp);
    for (int i = 0; i < 60 && state !== exp; i++) @(negedge clk_in);
    if (state !== exp) begin
      fails++;
      close_out();
    end
  endtask
  // The request is held over one rising edge, where ready is high in idle.
  task automatic send(input dtfc_req_t code);
    app_req = code;
    @(negedge clk_in);
    app_req = DTFC_REQ_NONE;
  endtask
  task automatic t_frame(input dtfc_req_t code, input dtfc_state_t bld, input dtfc_state_t sts,
      input logic [7:0] ty, input logic [3:0] n, input logic bad);
    logic [3:0] base;
    int d0;
    base = lk.n_words;
    d0 = done_cnt;
    bad_r = bad;
    send(code);
    chk_st(state, bld);
    chk(tx_req, 1'b1);
    if (bad) begin
      for (int i = 0; i < 60 && err_rep !== 1'b1; i++) @(negedge clk_in);
      chk(err_rep, 1'b1);
      if (err_rep !== 1'b1) close_out();
      chk_st(state, bld);
      bad_r = 1'b0;
    end
    wait_st(idle_state);
    chk_st(st_done, sts);
    chk(done_cnt - d0, bad ? 2 : 1);
    chk(4'(lk.n_words - base), bad ? 2 * n : n);
    chk(lk.words[base], {app_error, app_status, 8'h00, ty});
    chk(lk.words[4'(base + 4'h1)], 32'h0);
  endtask
  // Every other transmit code dispatches to its own entry state.
  task automatic t_dispatch();
    dtfc_req_t codes [5] = '{DTFC_REQ_PIO, DTFC_REQ_DMA_ACT, DTFC_REQ_DMA_SETUP,
      DTFC_REQ_DATA, DTFC_REQ_BIST};
    dtfc_state_t sts [5] = '{pio_setup_tx_entry, dma_activate_tx_entry, dma_setup_tx_entry,
      data_tx_entry, bist_tx_state};
    for (int i = 0; i < 5; i++) begin
      send(codes[i]);
      chk_st(state, sts[i]);
      wait_st(idle_state);
    end
  endtask
  // A PIO request leaves one data frame pending with its direction.
  task automatic t_pio();
    pio_dir = 1'b1;
    send(DTFC_REQ_PIO);
    pio_dir = 1'b0;
    wait_st(idle_state);
    chk({pio_pend, pio_dir_o}, 2'h3);
    send(DTFC_REQ_DATA);
    wait_st(idle_state);
    chk(pio_pend, 1'b0);
  endtask
  // An incoming frame enters type check; the type byte is shown only in that cycle.
  task automatic rx(input logic [7:0] ty, input logic ill, input dtfc_state_t exp);
    rx_start = 1'b1;
    @(negedge clk_in);
    chk_st(state, type_check_state);
    rx_start = 1'b0;
    rx_type = ty;
    illegal = ill;
    @(negedge clk_in);
    rx_type = ~ty;
    illegal = 1'b0;
    chk_st(state, exp);
    wait_st(idle_state);
  endtask
  // Start and request together: the frame wins and the request waits in idle.
  task automatic t_prio();
    app_req = DTFC_REQ_REG;
    rx_start = 1'b1;
    #1;
    chk(ready, 1'b0);
    @(negedge clk_in);
    chk_st(state, type_check_state);
    rx_start = 1'b0;
    rx_type = 8'hff;
    @(negedge clk_in);
    chk_st(state, idle_state);
    @(negedge clk_in);
    app_req = DTFC_REQ_NONE;
    chk_st(state, reg_build_state);
    wait_st(idle_state);
  endtask
  // Illegal-transition notices while building a register frame and awaiting SDB status.
  task automatic t_illegal();
    stall = 3'h5;
    send(DTFC_REQ_REG);
    illegal = 1'b1;
    @(negedge clk_in);
    illegal = 1'b0;
    chk_st(state, idle_state);
    repeat (12) @(negedge clk_in);
    send(DTFC_REQ_SDB);
    wait_st(sdb_status_state);
    illegal = 1'b1;
    @(negedge clk_in);
    illegal = 1'b0;
    chk_st(state, idle_state);
    repeat (12) @(negedge clk_in);
    stall = 3'h0;
  endtask
  // Main sequence: reset for three cycles, then each scenario in turn.
  initial begin
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
    rstn_in = 1'b1;
    chk({tx_req, word_valid, tx_done, err_rep, pio_pend}, 5'h00);
    repeat (3) @(negedge clk_in);
    chk_st(state, idle_state);
    app_status = 8'h5a;
    app_error = 8'hc3;
    t_frame(DTFC_REQ_REG, reg_build_state, reg_status_state, DTFC_TYPE_REG_D2H,
      4'h5, 1'b0);
    stall = 3'h2;
    t_frame(DTFC_REQ_SDB, sdb_build_state, sdb_status_state, DTFC_TYPE_SDB,
      4'h2, 1'b1);
    t_frame(DTFC_REQ_REG, reg_build_state, reg_status_state, DTFC_TYPE_REG_D2H,
      4'h5, 1'b1);
    stall = 3'h0;
    t_dispatch();
    t_pio();
    rx(DTFC_TYPE_REG_H2D, 1'b0, command_rx_state);
    rx(DTFC_TYPE_DATA, 1'b0, data_rx_entry);
    rx(DTFC_TYPE_DMA_SETUP, 1'b0, dma_setup_rx_entry);
    rx(DTFC_TYPE_BIST, 1'b0, bist_rx_state);
    rx(8'h00, 1'b0, idle_state);
    rx(DTFC_TYPE_REG_H2D, 1'b1, idle_state);
    t_prio();
    t_illegal();
    close_out();
  end
endmodule
